//--- dv/cbic_partner.sv
// Program memory and register file model facing the core
`timescale 1ns/1ps
module cbic_partner (
  input wire logic sys_clk_in,
  input wire cbic_pkg::cbic_addr_t prog_addr_in,
  output logic [7:0] prog_data_out,
  input wire logic [7:0] reg_raddr_in,
  output logic [7:0] reg_rdata_out,
  input wire logic reg_we_in,
  input wire logic [7:0] reg_waddr_in,
  input wire logic [7:0] reg_wdata_in
);
  import cbic_pkg::*;
  logic [7:0] prog_mem [0:255];
  logic [7:0] reg_mem [0:255];
  logic page_hit;
  // Outside the loaded page only the idle opcode is seen
  assign page_hit = (prog_addr_in[15:8] == 8'h00);
  assign prog_data_out = page_hit ? prog_mem[prog_addr_in[7:0]] : 8'h6F;
  assign reg_rdata_out = reg_mem[reg_raddr_in];
  always @(posedge sys_clk_in) begin
    if (reg_we_in === 1'b1) begin
      reg_mem[reg_waddr_in] <= reg_wdata_in;
    end
  end
endmodule : cbic_partner

//--- dv/cpu_branch_incr_ctrl_ops_bench.sv
// Self-checking bench running short programs through the core
`timescale 1ns/1ps
module cpu_branch_incr_ctrl_ops_bench;
  import cbic_pkg::*;
  logic sys_clk_in, rstn_in, irq_req_in, fast_sel_in;
  logic [7:0] work_base_in, prog_data, reg_rdata, reg_raddr;
  logic reg_we, irq_ack_out, cpu_clk_en_out;
  logic [7:0] reg_waddr, reg_wdata, flags_out, sys_mode_out;
  cbic_addr_t prog_addr, irq_vector_in, pc_out, sp_out, ip_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_ei = -1;
  int t_next = -1;
  cbic_core dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .work_base_in(work_base_in), .prog_addr_out(prog_addr),
    .prog_data_in(prog_data), .reg_raddr_out(reg_raddr),
    .reg_rdata_in(reg_rdata), .reg_we_out(reg_we),
    .reg_waddr_out(reg_waddr), .reg_wdata_out(reg_wdata),
    .irq_req_in(irq_req_in), .fast_sel_in(fast_sel_in),
    .irq_vector_in(irq_vector_in), .irq_ack_out(irq_ack_out),
    .cpu_clk_en_out(cpu_clk_en_out), .pc_out(pc_out), .sp_out(sp_out),
    .ip_out(ip_out), .flags_out(flags_out), .sys_mode_out(sys_mode_out));
  cbic_partner pm (.sys_clk_in(sys_clk_in), .prog_addr_in(prog_addr),
    .prog_data_out(prog_data), .reg_raddr_in(reg_raddr),
    .reg_rdata_out(reg_rdata), .reg_we_in(reg_we),
    .reg_waddr_in(reg_waddr), .reg_wdata_in(reg_wdata));
  always #5 sys_clk_in = ~sys_clk_in;
  // Fetch-address timing of the enable opcode at 0003
  always @(negedge sys_clk_in) begin
    cyc++;
    if (prog_addr === 16'h0003 && t_ei < 0) t_ei = cyc;
    if (prog_addr === 16'h0004 && t_next < 0) t_next = cyc;
  end
  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stall();
    n_mismatch++;
    $display("MISMATCH at %0t: wait ran out", $time);
    close_out();
  endtask : stall
  task automatic load(input bit rf, input int a, input logic [7:0] b[$]);
    foreach (b[i]) begin
      if (rf) pm.reg_mem[a + i] = b[i];
      else pm.prog_mem[a + i] = b[i];
    end
  endtask : load
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic wait_idle();
    int k;
    k = 0;
    while (cpu_clk_en_out !== 1'b0 && k < 300) begin
      tick();
      k++;
    end
    if (k >= 300) stall();
    tick();
  endtask : wait_idle
  // One-cycle request only wakes, never gets taken
  task automatic wake();
    irq_req_in = 1'b1;
    tick();
    irq_req_in = 1'b0;
  endtask : wake
  task automatic take(input logic fast);
    int k;
    k = 0;
    irq_req_in = 1'b1;
    fast_sel_in = fast;
    while (irq_ack_out !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    irq_req_in = 1'b0;
    if (k >= 50) stall();
  endtask : take
  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done
  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    rstn_in = 1'b0;
    irq_req_in = 1'b0;
    fast_sel_in = 1'b0;
    work_base_in = 8'hC0;
    irq_vector_in = 16'h00A0;
    for (int i = 0; i < 256; i++) begin
      pm.prog_mem[i] = 8'h6F;
      pm.reg_mem[i] = 8'h00;
    end
    load(1, 'h00, '{8'hD0, 8'h00, 8'hB0});
    load(1, 'hC4, '{8'h7F, 8'hFF});
    load(1, 'hC8, '{8'hD1, 8'h00, 8'hD1, 8'h00, 8'h00, 8'hC0});
    load(1, 'hD0, '{8'hFF, 8'h0F});
    load(0, 'h00, '{8'h1C, 8'h7F, 8'h1E, 8'h9F, 8'h6F});
    load(0, 'h05, '{8'h2C, 8'h03, 8'h2A, 8'hFE, 8'hA0, 8'hC4, 8'h20,
      8'hD0, 8'h6F, 8'h8D, 8'h00, 8'h40});
    load(0, 'h40, '{8'h0D, 8'h00, 8'h50, 8'h8B, 8'h02, 8'h6F, 8'h6F,
      8'hEB, 8'h02, 8'h3C, 8'h5A, 8'h6F, 8'h1F, 8'h00, 8'h60});
    load(0, 'h60, '{8'h3C, 8'h77, 8'h6F, 8'h4C, 8'h00, 8'h49, 8'hFE,
      8'h4C, 8'h80, 8'h49, 8'hFF, 8'h2F});
    load(0, 'h80, '{8'h00, 8'h90, 8'h7C, 8'h11, 8'hBF});
    load(0, 'h90, '{8'h5C, 8'h33, 8'h6F});
    load(0, 'hA0, '{8'h68, 8'hC3, 8'hBF});
    load(0, 'hB0, '{8'h6F, 8'h6F, 8'h21, 8'hC8, 8'hC7, 8'h9A, 8'h30,
      8'hCC, 8'h6F, 8'h6F, 8'h6F});
    load(0, 'hC0, '{8'hBC, 8'h99, 8'h6F});
    repeat (12) @(posedge sys_clk_in);
    #1;
    rstn_in = 1'b1;
    wait_idle();
    check(pm.reg_mem[8'hC1], 8'h80);
    check(flags_out[7:4], 4'h3);
    check(sys_mode_out[0], 1'b1);
    check(16'(t_next - t_ei), 16'h0004);
    done("load_inc_enable");
    wake();
    wait_idle();
    check(pm.reg_mem[8'hC2], 8'h00);
    check({pm.reg_mem[8'hC4], pm.reg_mem[8'hC5]}, 16'h8000);
    check(pm.reg_mem[8'hD0], 8'h00);
    check(flags_out[7:4], 4'h4);
    done("count_down_and_words");
    wake();
    wait_idle();
    check(pm.reg_mem[8'hC3], 8'h5A);
    done("branches");
    wake();
    wait_idle();
    check(pm.reg_mem[8'hC3], 8'h77);
    check(sp_out, 16'hFFFE);
    check(ip_out, 16'h004F);
    done("enter");
    wake();
    wait_idle();
    check(pm.reg_mem[8'hC5], 8'h33);
    check(sp_out, 16'h0000);
    check(ip_out, 16'h0082);
    done("exit");
    take(1'b0);
    check(pc_out, 16'h00A0);
    check(sys_mode_out[0], 1'b0);
    wait_idle();
    check(pm.reg_mem[8'hC6], 8'h77);
    check(flags_out, 8'hD0);
    check(sp_out, 16'h0003);
    check(sys_mode_out[0], 1'b1);
    done("normal_return");
    take(1'b1);
    check(pc_out, 16'h0082);
    check(ip_out, 16'h00B1);
    check(flags_out, 8'hD2);
    wait_idle();
    check(pm.reg_mem[8'hC7], 8'h11);
    check(flags_out, 8'hD0);
    check(ip_out, 16'h0085);
    done("quick_return");
    wake();
    wait_idle();
    check(pm.reg_mem[8'hD1], 8'h10);
    check(pm.reg_mem[8'hC9], 8'h10);
    check(pm.reg_mem[8'hCB], 8'h99);
    done("indirect_forms");
    close_out();
  end
endmodule : cpu_branch_incr_ctrl_ops_bench

//--- src/cbic_core.sv
// Multi-cycle execution core for the branch, increment and control slice
`timescale 1ns/1ps
// Functional notes
// - Count-down-branch decrements working reg, branches if nonzero
// - Global enable opcode 9F sets mode bit zero; 4 cycles; flags kept
// - Pending request is serviced at the fetch after enable is set
// - Enter: SP-2, push thread ptr, ptr=PC, PC=@ptr, ptr+2
// - Exit: pop thread ptr, stack up 2, PC=@ptr, ptr+2; 14 cycles
// - Idle 6F stops the CPU clock until an interrupt request
// - Byte increment sets Z, S, V; keeps C, D, H; rE, 20, 21
// - Word increment on even pair with carry, same flags; A0, A1
// - Service return pops flags, then PC, sets global enable; 10 cycles
// - Quick flag set: return swaps PC/ptr, restores shadow; 6 cycles
// - Quick service entry swaps PC and thread pointer
// - Absolute branch loads target when condition holds for ccD, always for 30
// - Relative branch adds signed displacement to next address; 6 cycles
// - Byte move copies source, keeps flags; rC, r8, r9, C7; 4 cycles
module cbic_core (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] work_base_in,
  output cbic_pkg::cbic_addr_t prog_addr_out,
  input wire logic [7:0] prog_data_in,
  output logic [7:0] reg_raddr_out,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_we_out,
  output logic [7:0] reg_waddr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic irq_req_in,
  input wire logic fast_sel_in,
  input wire cbic_pkg::cbic_addr_t irq_vector_in,
  output logic irq_ack_out,
  output logic cpu_clk_en_out,
  output cbic_pkg::cbic_addr_t pc_out,
  output cbic_pkg::cbic_addr_t sp_out,
  output cbic_pkg::cbic_addr_t ip_out,
  output logic [7:0] flags_out,
  output logic [7:0] sys_mode_out
);
  import cbic_pkg::*;
  // -----------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------
  logic [1:0] rst_pipe_reg;
  wire rst_ok_n = rst_pipe_reg[1];
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) rst_pipe_reg <= 2'b00;
    else rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  // -----------------------------------------------------------
  // State
  // -----------------------------------------------------------
  cbic_state_t state_reg;
  logic [15:0] pc_reg, sp_reg, ip_reg, wrd_reg;
  logic [7:0] op_reg, tmp_reg, ea_reg, flags_reg, shadow_reg, mode_reg;
  logic [3:0] cyc_reg;
  logic quick_reg, we_reg, ack_reg;
  logic [7:0] waddr_reg, wdata_reg;
  // -----------------------------------------------------------
  // Decode
  // -----------------------------------------------------------
  wire [3:0] op_hi = op_reg[7:4];
  wire [3:0] op_lo = op_reg[3:0];
  wire exec = state_reg == CBIC_EXEC;
  wire fetch = state_reg == CBIC_FETCH;
  wire [15:0] at = exec ? (16'h0001 << cyc_reg) : 16'h0000;
  wire is_count_down_branch = op_lo == NIB_COUNT_DOWN_BRANCH;
  wire is_inc1 = op_lo == NIB_INC;
  wire is_jpcc = op_lo == NIB_JP;
  wire is_jr = op_lo == NIB_JR;
  wire is_ldim = op_lo == NIB_LD_IM;
  wire is_ld8 = op_lo == NIB_LD_RW;
  wire is_ld9 = op_lo == NIB_LD_WR;
  wire is_gie = op_reg == OP_GIE;
  wire is_enter = op_reg == OP_ENTER;
  wire is_exit = op_reg == OP_EXIT;
  wire is_idle = op_reg == OP_IDLE;
  wire is_service_return = op_reg == OP_SERVICE_RETURN;
  wire is_jp30 = op_reg == OP_JP_IRR;
  wire is_c7 = op_reg == OP_LD_IND;
  wire is_inc2 = (op_reg == OP_INC_R) || (op_reg == OP_INC_IR);
  wire is_add_one_word = (op_reg == OP_ADD_ONE_WORD_RR) || (op_reg == OP_ADD_ONE_WORD_IR);
  wire is_ld = is_ldim | is_ld8 | is_ld9 | is_c7;
  wire [3:0] instr_len =
    is_count_down_branch ? CYC_COUNT_DOWN_BRANCH :
    (is_enter | is_exit) ? CYC_THREAD :
    is_add_one_word ? CYC_ADD_ONE_WORD :
    is_service_return ? (quick_reg ? CYC_SERVICE_RETURN_FAST : CYC_SERVICE_RETURN) :
    (is_jpcc | is_jp30) ? CYC_JP :
    is_jr ? CYC_JR : CYC_SHORT;
  wire last = exec && (cyc_reg == instr_len - 4'h1);
  wire irq_take = fetch && irq_req_in && mode_reg[SYM_GIE];
  // Condition code: low three bits pick a test, top bit inverts it
  wire sv = flags_reg[FLG_S] ^ flags_reg[FLG_V];
  logic cc_base;
  always_comb begin
    case (op_hi[2:0])
      3'h0: cc_base = 1'b0;
      3'h1: cc_base = sv;
      3'h2: cc_base = flags_reg[FLG_Z] | sv;
      3'h3: cc_base = flags_reg[FLG_C] | flags_reg[FLG_Z];
      3'h4: cc_base = flags_reg[FLG_V];
      3'h5: cc_base = flags_reg[FLG_S];
      3'h6: cc_base = flags_reg[FLG_Z];
      default: cc_base = flags_reg[FLG_C];
    endcase
  end
  wire cond_ok = cc_base ^ op_hi[3];
  // -----------------------------------------------------------
  // Address and arithmetic paths
  // -----------------------------------------------------------
  wire [7:0] wr_addr = {work_base_in[7:4], op_hi};
  wire [15:0] pc_inc = pc_reg + 16'h0001;
  wire [15:0] rel_tgt = pc_reg + {{8{tmp_reg[7]}}, tmp_reg};
  wire [15:0] jr_tgt = pc_inc + {{8{prog_data_in[7]}}, prog_data_in};
  wire stk_off = (is_exit & at[2]) | (is_service_return & at[3]);
  wire [7:0] stk_addr = sp_reg[7:0] + {7'h00, stk_off};
  wire pair_lo = (is_add_one_word | is_jp30) & at[3];
  // Byte increment and step 2 keep the full operand address, pairs force odd at step 3, else even
  wire [7:0] pair_addr =
    (at[2] | is_inc2) ? ea_reg : {ea_reg[7:1], pair_lo};
  assign reg_raddr_out =
    (is_exit | is_service_return) ? stk_addr :
    (is_count_down_branch | is_inc1 | is_ld9) ? wr_addr :
    is_ld8 ? ea_reg :
    is_c7 ? (at[2] ? {work_base_in[7:4], ea_reg[3:0]} : tmp_reg) :
    pair_addr;
  wire ip_rd = (is_enter & (at[5] | at[6])) | (is_exit & (at[4] | at[5]));
  wire ip_odd = (is_enter & at[6]) | (is_exit & at[5]);
  assign prog_addr_out = ip_rd ? (ip_reg + {15'h0000, ip_odd}) : pc_reg;
  wire [7:0] dec_res = reg_rdata_in - 8'h01;
  wire [7:0] inc_res = reg_rdata_in + 8'h01;
  wire [15:0] wsum = {reg_rdata_in, tmp_reg} + 16'h0001;
  wire byte_upd = (is_inc1 & at[1]) | (is_inc2 & at[3]);
  wire word_upd = is_add_one_word & at[4];
  wire zf = word_upd ? (wsum == 16'h0000) : (inc_res == 8'h00);
  wire sf = word_upd ? wsum[15] : inc_res[7];
  wire vf = word_upd ? (wsum == 16'h8000) : (inc_res == 8'h80);
  // -----------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      state_reg <= CBIC_FETCH;
      pc_reg <= RST_PC;
      sp_reg <= RST_SP;
      ip_reg <= RST_IP;
      wrd_reg <= RST_PC;
      op_reg <= RST_BYTE;
      tmp_reg <= RST_BYTE;
      ea_reg <= RST_BYTE;
      flags_reg <= RST_BYTE;
      shadow_reg <= RST_BYTE;
      mode_reg <= RST_BYTE;
      cyc_reg <= 4'h0;
      quick_reg <= 1'b0;
      we_reg <= 1'b0;
      ack_reg <= 1'b0;
      waddr_reg <= RST_BYTE;
      wdata_reg <= RST_BYTE;
    end else begin
      we_reg <= 1'b0;
      ack_reg <= 1'b0;
      case (state_reg)
        CBIC_FETCH: begin
          if (irq_take) begin
            ack_reg <= 1'b1;
            mode_reg[SYM_GIE] <= 1'b0;
            if (fast_sel_in) begin
              pc_reg <= ip_reg;
              ip_reg <= pc_reg;
              shadow_reg <= flags_reg;
              flags_reg[FLG_QS] <= 1'b1;
            end else begin
              pc_reg <= irq_vector_in;
            end
          end else begin
            op_reg <= prog_data_in;
            quick_reg <= flags_reg[FLG_QS];
            pc_reg <= pc_inc;
            cyc_reg <= 4'h1;
            state_reg <= CBIC_EXEC;
          end
        end
        CBIC_EXEC: begin
          cyc_reg <= cyc_reg + 4'h1;
          if (last) state_reg <= is_idle ? CBIC_IDLE : CBIC_FETCH;
          // Operand byte fetch
          if (at[1] & (is_count_down_branch | is_jpcc)) tmp_reg <= prog_data_in;
          if (at[1] & (is_inc2 | is_add_one_word | is_jp30 | is_ld8 | is_ld9 | is_c7))
            ea_reg <= prog_data_in;
          if (at[1] & ~(is_gie | is_enter | is_exit | is_idle | is_service_return
              | is_inc1 | is_jr))
            pc_reg <= pc_inc;
          if (at[2] & is_count_down_branch) begin
            we_reg <= 1'b1;
            waddr_reg <= wr_addr;
            wdata_reg <= dec_res;
            if (dec_res != 8'h00) pc_reg <= rel_tgt;
          end
          if (at[1] & is_gie) mode_reg[SYM_GIE] <= 1'b1;
          // Thread entry and exit
          if (at[1] & is_enter) sp_reg <= sp_reg - PAIR_STEP;
          if ((at[2] | at[3]) & is_enter) begin
            we_reg <= 1'b1;
            waddr_reg <= sp_reg[7:0] + {7'h00, at[3]};
            wdata_reg <= at[2] ? ip_reg[15:8] : ip_reg[7:0];
          end
          if (at[4] & is_enter) ip_reg <= pc_reg;
          if (at[5] & is_enter) tmp_reg <= prog_data_in;
          if (at[6] & is_enter) pc_reg <= {tmp_reg, prog_data_in};
          if (at[7] & is_enter) ip_reg <= ip_reg + PAIR_STEP;
          if (at[1] & is_exit) tmp_reg <= reg_rdata_in;
          if (at[2] & is_exit) ip_reg <= {tmp_reg, reg_rdata_in};
          if (at[3] & is_exit) sp_reg <= sp_reg + PAIR_STEP;
          if (at[4] & is_exit) tmp_reg <= prog_data_in;
          if (at[5] & is_exit) pc_reg <= {tmp_reg, prog_data_in};
          if (at[6] & is_exit) ip_reg <= ip_reg + PAIR_STEP;
          // Increments
          if (at[2] & (is_inc2 | is_add_one_word) & op_reg[0]) ea_reg <= reg_rdata_in;
          if (at[3] & is_add_one_word) tmp_reg <= reg_rdata_in;
          if (byte_upd) begin
            we_reg <= 1'b1;
            waddr_reg <= reg_raddr_out;
            wdata_reg <= inc_res;
          end
          if (word_upd) begin
            wrd_reg <= wsum;
            we_reg <= 1'b1;
            waddr_reg <= {ea_reg[7:1], 1'b0};
            wdata_reg <= wsum[15:8];
          end
          if (at[5] & is_add_one_word) begin
            we_reg <= 1'b1;
            waddr_reg <= {ea_reg[7:1], 1'b1};
            wdata_reg <= wrd_reg[7:0];
          end
          if (byte_upd | word_upd) begin
            flags_reg[FLG_Z] <= zf;
            flags_reg[FLG_S] <= sf;
            flags_reg[FLG_V] <= vf;
          end
          // Service return
          if (at[1] & is_service_return & quick_reg) begin
            pc_reg <= ip_reg;
            ip_reg <= pc_reg;
            flags_reg <= shadow_reg & ~(8'h01 << FLG_QS);
          end
          if (at[1] & is_service_return & ~quick_reg) begin
            flags_reg <= reg_rdata_in;
            sp_reg <= sp_reg + 16'h0001;
          end
          if (at[2] & is_service_return & ~quick_reg) tmp_reg <= reg_rdata_in;
          if (at[3] & is_service_return & ~quick_reg) begin
            pc_reg <= {tmp_reg, reg_rdata_in};
            sp_reg <= sp_reg + PAIR_STEP;
            mode_reg[SYM_GIE] <= 1'b1;
          end
          // Branches
          if (at[2] & is_jpcc)
            pc_reg <= cond_ok ? {tmp_reg, prog_data_in} : pc_inc;
          if (at[2] & is_jp30) tmp_reg <= reg_rdata_in;
          if (at[3] & is_jp30) pc_reg <= {tmp_reg, reg_rdata_in};
          if (at[1] & is_jr) pc_reg <= cond_ok ? jr_tgt : pc_inc;
          // Byte moves
          if ((at[1] & is_ldim) | (at[2] & (is_ld8 | is_ld9))) begin
            we_reg <= 1'b1;
            waddr_reg <= is_ld9 ? ea_reg : wr_addr;
            wdata_reg <= is_ldim ? prog_data_in : reg_rdata_in;
          end
          if (at[2] & is_c7) tmp_reg <= reg_rdata_in;
          if (at[3] & is_c7) begin
            we_reg <= 1'b1;
            waddr_reg <= {work_base_in[7:4], ea_reg[7:4]};
            wdata_reg <= reg_rdata_in;
          end
        end
        CBIC_IDLE: if (irq_req_in) state_reg <= CBIC_FETCH;
        default: state_reg <= CBIC_FETCH;
      endcase
    end
  end
  assign reg_we_out = we_reg;
  assign reg_waddr_out = waddr_reg;
  assign reg_wdata_out = wdata_reg;
  assign irq_ack_out = ack_reg;
  assign cpu_clk_en_out = state_reg != CBIC_IDLE;
  assign pc_out = pc_reg;
  assign sp_out = sp_reg;
  assign ip_out = ip_reg;
  assign flags_out = flags_reg;
  assign sys_mode_out = mode_reg;
  // -----------------------------------------------------------
  // Checks
  // -----------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_ok_n);
  wire start = fetch && !irq_take;
  a_count_down_branch_taken: assert property (
    at[2] && is_count_down_branch && dec_res != 8'h00 |=> pc_reg == $past(rel_tgt))
    else $error("count-down branch target wrong");
  a_gie_len: assert property (
    start && prog_data_in == OP_GIE |=> exec [*3] ##1
    (fetch && mode_reg[SYM_GIE] && $stable(flags_reg)))
    else $error("global enable wrong");
  a_irq_ack: assert property (
    irq_take |=> irq_ack_out && !mode_reg[SYM_GIE])
    else $error("pending request not serviced");
  a_enter_stack: assert property (
    start && prog_data_in == OP_ENTER |=> ##1
    sp_reg == $past(sp_reg, 2) - PAIR_STEP ##12 fetch)
    else $error("enter stack or length wrong");
  a_exit_ptr: assert property (
    at[6] && is_exit |=> ip_reg == $past(ip_reg) + PAIR_STEP)
    else $error("exit pointer step wrong");
  a_idle_clock: assert property (
    last && is_idle |=> !cpu_clk_en_out ##0
    (!cpu_clk_en_out throughout (!irq_req_in [*1])) or irq_req_in)
    else $error("idle did not stop clock");
  a_inc_flags: assert property (
    byte_upd |=> reg_wdata_out == $past(reg_rdata_in) + 8'h01 &&
    flags_reg[FLG_C] == $past(flags_reg[FLG_C]))
    else $error("byte increment wrong");
  a_add_one_word_carry: assert property (
    word_upd |=> ##1 reg_we_out && reg_waddr_out[0] &&
    reg_wdata_out == $past(wsum[7:0], 2))
    else $error("word increment low byte wrong");
  a_service_return_norm: assert property (
    at[3] && is_service_return && !quick_reg |=> mode_reg[SYM_GIE] ##6 fetch)
    else $error("service return wrong");
  a_service_return_quick: assert property (
    start && prog_data_in == OP_SERVICE_RETURN && flags_reg[FLG_QS] |=>
    exec [*5] ##1 (fetch && pc_reg == $past(ip_reg, 6) &&
    !flags_reg[FLG_QS]))
    else $error("quick return wrong");
  a_quick_swap: assert property (
    irq_take && fast_sel_in |=> pc_reg == $past(ip_reg) &&
    ip_reg == $past(pc_reg))
    else $error("quick entry swap wrong");
  a_jr_skip: assert property (
    at[1] && is_jr && !cond_ok |=> pc_reg == $past(pc_inc))
    else $error("relative branch fell wrong");
  a_ld_flags: assert property (
    exec && is_ld |=> $stable(flags_reg))
    else $error("move changed flags");
  c_count_down_branch_loop: cover property (at[2] && is_count_down_branch && dec_res != 8'h00);
  c_quick_trip: cover property (irq_take && fast_sel_in);
  c_idle_wake: cover property (state_reg == CBIC_IDLE && irq_req_in);
endmodule : cbic_core

//--- src/cbic_pkg.sv
// Shared constants and types for the branch/increment/control core
package cbic_pkg;
  typedef logic [15:0] cbic_addr_t;
  typedef enum logic [1:0] {
    CBIC_FETCH = 2'b00,
    CBIC_EXEC = 2'b01,
    CBIC_IDLE = 2'b10
  } cbic_state_t;
  // -----------------------------------------------------------
  // Full-byte opcodes
  // -----------------------------------------------------------
  localparam logic [7:0] OP_GIE = 8'h9F;
  localparam logic [7:0] OP_ENTER = 8'h1F;
  localparam logic [7:0] OP_EXIT = 8'h2F;
  localparam logic [7:0] OP_IDLE = 8'h6F;
  localparam logic [7:0] OP_INC_R = 8'h20;
  localparam logic [7:0] OP_INC_IR = 8'h21;
  localparam logic [7:0] OP_ADD_ONE_WORD_RR = 8'hA0;
  localparam logic [7:0] OP_ADD_ONE_WORD_IR = 8'hA1;
  localparam logic [7:0] OP_SERVICE_RETURN = 8'hBF;
  localparam logic [7:0] OP_JP_IRR = 8'h30;
  localparam logic [7:0] OP_LD_IND = 8'hC7;
  // -----------------------------------------------------------
  // Low-nibble opcodes, high nibble is register or condition
  // -----------------------------------------------------------
  localparam logic [3:0] NIB_COUNT_DOWN_BRANCH = 4'hA;
  localparam logic [3:0] NIB_INC = 4'hE;
  localparam logic [3:0] NIB_JP = 4'hD;
  localparam logic [3:0] NIB_JR = 4'hB;
  localparam logic [3:0] NIB_LD_IM = 4'hC;
  localparam logic [3:0] NIB_LD_RW = 4'h8;
  localparam logic [3:0] NIB_LD_WR = 4'h9;
  // -----------------------------------------------------------
  // Cycle counts, fetch cycle included
  // -----------------------------------------------------------
  localparam logic [3:0] CYC_COUNT_DOWN_BRANCH = 4'h8;
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_THREAD = 4'hE;
  localparam logic [3:0] CYC_ADD_ONE_WORD = 4'h8;
  localparam logic [3:0] CYC_SERVICE_RETURN = 4'hA;
  localparam logic [3:0] CYC_SERVICE_RETURN_FAST = 4'h6;
  localparam logic [3:0] CYC_JP = 4'h8;
  localparam logic [3:0] CYC_JR = 4'h6;
  // -----------------------------------------------------------
  // Flag and mode bits, reset values
  // -----------------------------------------------------------
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_QS = 1;
  localparam int SYM_GIE = 0;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [15:0] RST_IP = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] PAIR_STEP = 16'h0002;
endpackage : cbic_pkg
